/* design/cspc_pkg.sv */
// Package of constants and carrier types for the CPU stack and pointer core
package cspc_pkg;
  localparam int STACK_W = 15;
  localparam int STACK_DEPTH = 16;
  localparam int PTR_W = 16;
  localparam int PROG_SEL_BIT = 15;
  localparam int GPR_BANK_BYTES = 80;
  localparam int INSN_COUNT = 49;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LIMIT = 16'h29b0;
  localparam logic [6:0] GPR_OFFSET = 7'h20;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [1:0] STACK_ERR_RST = 2'h0;
  localparam int PM_EXTRA_CYCLES = 1;

  typedef enum logic [1:0] {
    CSPC_OP_NONE = 2'b00,
    CSPC_OP_PUSH = 2'b01,
    CSPC_OP_POP = 2'b10
  } cspc_stack_op_t;

  typedef enum logic [1:0] {
    CSPC_IND_IDLE = 2'b00,
    CSPC_IND_FETCH = 2'b01
  } cspc_ind_state_t;

  typedef struct packed {
    logic [7:0] wreg;
    logic [2:0] status;
    logic [4:0] bank;
    logic [6:0] pclath;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
  } cspc_context_t;

  typedef struct packed {
    logic valid;
    logic sel;
    logic write;
    logic [7:0] wdata;
  } cspc_ind_req_t;

  // Linear window address to banked data address
  function automatic logic [11:0] cspc_linear_map(input logic [15:0] addr);
    logic [15:0] off;
    logic [15:0] bank;
    logic [15:0] idx;
    off = addr - LIN_BASE;
    bank = off / 16'(GPR_BANK_BYTES);
    idx = off % 16'(GPR_BANK_BYTES);
    return {bank[4:0], 7'(idx[6:0] + GPR_OFFSET)};
  endfunction
endpackage

/* design/cspc_stack.sv */
// Hardware return-address stack with overflow and underflow detection
`timescale 1ns/1ps
module cspc_stack
  import cspc_pkg::*;
#(
  parameter int WIDTH = STACK_W,
  parameter int DEPTH = STACK_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic soft_clr,
  input wire cspc_stack_op_t op,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top_q,
  output logic ovf_evt,
  output logic unf_evt
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH):0] cnt_q;
  wire full = (cnt_q == ($clog2(DEPTH)+1)'(DEPTH));
  wire empty = (cnt_q == '0);
  wire do_push = (op == CSPC_OP_PUSH) && !full;
  wire do_pop = (op == CSPC_OP_POP) && !empty;
  wire [$clog2(DEPTH)-1:0] wr_idx = cnt_q[$clog2(DEPTH)-1:0];
  wire [$clog2(DEPTH)-1:0] rd_idx = wr_idx - 1'b1;

  assign ovf_evt = (op == CSPC_OP_PUSH) && full;
  assign unf_evt = (op == CSPC_OP_POP) && empty;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_idx] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (soft_clr) begin
      cnt_q <= '0;
    end else if (do_push) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (do_pop) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      top_q <= '0;
    end else if (do_pop) begin
      top_q <= mem[rd_idx];
    end
  end

  property p_count_bound;
    @(posedge clk) disable iff (!arst_n) cnt_q <= ($clog2(DEPTH)+1)'(DEPTH);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("stack count past depth");
endmodule

/* design/cspc_core.sv */
// CPU core stack, context shadow and indirect pointer logic
`timescale 1ns/1ps
//
// Summary of operation
// - Return stack is 16 deep, 15 bits wide.
// - Overflow or underflow sets its status flag.
// - Enabled stack error forces software reset.
// - Interrupt entry shadows registers; return restores.
// - Two 16-bit pointers reach data and program.
// - Program memory via port adds one cycle.
// - Linear window spans GPR across banks.
// - Decoder supports exactly 49 instructions.
// - Pointer bit 15 selects program; low byte read.
// - Port writes never alter program memory.
module cspc_core
  import cspc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire cspc_stack_op_t stack_op,
  input wire logic [STACK_W-1:0] ret_addr,
  input wire logic stack_rst_en,
  input wire logic flag_clr_ovf,
  input wire logic flag_clr_unf,
  input wire logic irq_enter,
  input wire logic irq_return,
  input wire cspc_context_t live_ctx,
  input wire logic ptr_wr,
  input wire logic ptr_wr_sel,
  input wire logic [PTR_W-1:0] ptr_wr_data,
  input wire cspc_ind_req_t ind_req,
  input wire logic [13:0] prog_rdata,
  input wire logic [7:0] data_rdata,
  input wire logic [6:0] insn_index,
  output logic [STACK_W-1:0] ret_top,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  output logic soft_reset,
  output cspc_context_t shadow_ctx,
  output logic restore_valid,
  output logic [PTR_W-1:0] indirect_address_pointer0,
  output logic [PTR_W-1:0] indirect_address_pointer1,
  output logic [14:0] prog_addr,
  output logic [11:0] data_addr,
  output logic data_we,
  output logic [7:0] data_wdata,
  output logic [7:0] indirect_data_port,
  output logic ind_done,
  output logic cpu_stall,
  output logic insn_legal
);
  ////////////////////////////////////////////////////////////////////////////
  // Stack and error flags
  logic ovf_evt;
  logic unf_evt;
  logic soft_reset_d;

  cspc_stack #(.WIDTH(STACK_W), .DEPTH(STACK_DEPTH)) u_stack (
    .clk(clk),
    .arst_n(arst_n),
    .soft_clr(soft_reset),
    .op(stack_op),
    .push_data(ret_addr),
    .top_q(ret_top),
    .ovf_evt(ovf_evt),
    .unf_evt(unf_evt)
  );

  assign soft_reset_d = stack_rst_en && (ovf_evt || unf_evt);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= soft_reset_d;
    end
  end

  // Set beats clear; flags survive a stack-caused reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {stack_overflow_flag, stack_underflow_flag} <= STACK_ERR_RST;
    end else begin
      if (ovf_evt) begin
        stack_overflow_flag <= 1'b1;
      end else if (flag_clr_ovf) begin
        stack_overflow_flag <= 1'b0;
      end
      if (unf_evt) begin
        stack_underflow_flag <= 1'b1;
      end else if (flag_clr_unf) begin
        stack_underflow_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Context shadow
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_ctx <= '0;
      restore_valid <= 1'b0;
    end else begin
      if (irq_enter) begin
        shadow_ctx <= live_ctx;
      end
      restore_valid <= irq_return;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indirect pointers
  logic [PTR_W-1:0] ptr_q [2];
  cspc_ind_state_t ind_state_q;
  cspc_ind_state_t ind_state_d;
  wire [PTR_W-1:0] cur_ptr = ptr_q[ind_req.sel];
  wire to_prog = cur_ptr[PROG_SEL_BIT];
  wire in_linear = (cur_ptr >= LIN_BASE) && (cur_ptr < LIN_LIMIT);
  wire [11:0] mapped = in_linear ? cspc_linear_map(cur_ptr) : cur_ptr[11:0];
  wire start_prog = ind_req.valid && to_prog && (ind_state_q == CSPC_IND_IDLE);
  wire start_data = ind_req.valid && !to_prog && (ind_state_q == CSPC_IND_IDLE);

  always_comb begin
    case (ind_state_q)
      CSPC_IND_IDLE: ind_state_d = start_prog ? CSPC_IND_FETCH : CSPC_IND_IDLE;
      CSPC_IND_FETCH: ind_state_d = CSPC_IND_IDLE;
      default: ind_state_d = CSPC_IND_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q[0] <= PTR_RST;
      ptr_q[1] <= PTR_RST;
    end else if (ptr_wr) begin
      ptr_q[ptr_wr_sel] <= ptr_wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ind_state_q <= CSPC_IND_IDLE;
      prog_addr <= '0;
      data_addr <= '0;
      data_we <= 1'b0;
      data_wdata <= '0;
      indirect_data_port <= '0;
      ind_done <= 1'b0;
      cpu_stall <= 1'b0;
    end else begin
      ind_state_q <= ind_state_d;
      data_we <= start_data && ind_req.write;
      ind_done <= start_data || (ind_state_q == CSPC_IND_FETCH);
      cpu_stall <= start_prog;
      if (start_prog) begin
        prog_addr <= cur_ptr[14:0];
      end
      if (start_data) begin
        data_addr <= mapped;
        data_wdata <= ind_req.wdata;
        indirect_data_port <= data_rdata;
      end
      if (ind_state_q == CSPC_IND_FETCH) begin
        indirect_data_port <= prog_rdata[7:0];
      end
    end
  end

  assign indirect_address_pointer0 = ptr_q[0];
  assign indirect_address_pointer1 = ptr_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode range
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      insn_legal <= 1'b0;
    end else begin
      insn_legal <= (insn_index < 7'(INSN_COUNT));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_prog_req;
    start_prog;
  endsequence

  property p_flag_set_ovf;
    @(posedge clk) disable iff (!arst_n) ovf_evt |=> stack_overflow_flag;
  endproperty
  a_flag_set_ovf: assert property (p_flag_set_ovf) else $error("overflow flag not set");

  property p_flag_set_unf;
    @(posedge clk) disable iff (!arst_n) unf_evt |=> stack_underflow_flag;
  endproperty
  a_flag_set_unf: assert property (p_flag_set_unf) else $error("underflow flag not set");

  property p_soft_rst;
    @(posedge clk) disable iff (!arst_n)
      (stack_rst_en && (ovf_evt || unf_evt)) |=> soft_reset;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("no soft reset on stack error");

  property p_no_soft_rst;
    @(posedge clk) disable iff (!arst_n) !stack_rst_en |=> !soft_reset;
  endproperty
  a_no_soft_rst: assert property (p_no_soft_rst) else $error("soft reset while disabled");

  property p_shadow;
    @(posedge clk) disable iff (!arst_n) irq_enter |=> shadow_ctx == $past(live_ctx);
  endproperty
  a_shadow: assert property (p_shadow) else $error("context not shadowed");

  property p_extra_cycle;
    @(posedge clk) disable iff (!arst_n) s_prog_req |=> cpu_stall ##1 ind_done;
  endproperty
  a_extra_cycle: assert property (p_extra_cycle) else $error("program read cycle count");

  property p_prog_low_byte;
    @(posedge clk) disable iff (!arst_n)
      s_prog_req |=> ##1 indirect_data_port == $past(prog_rdata[7:0]);
  endproperty
  a_prog_low_byte: assert property (p_prog_low_byte) else $error("wrong program byte");

  property p_no_prog_write;
    @(posedge clk) disable iff (!arst_n) s_prog_req |=> !data_we;
  endproperty
  a_no_prog_write: assert property (p_no_prog_write) else $error("write to program space");

  property p_ptr_load;
    @(posedge clk) disable iff (!arst_n)
      (ptr_wr && !ptr_wr_sel) |=> indirect_address_pointer0 == $past(ptr_wr_data);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_flags_kept;
    @(posedge clk) disable iff (!arst_n)
      (soft_reset && stack_overflow_flag && !flag_clr_ovf) |=> stack_overflow_flag;
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flag lost on stack reset");

  property p_linear;
    @(posedge clk) disable iff (!arst_n)
      (start_data && in_linear) |=> data_addr[6:0] >= GPR_OFFSET;
  endproperty
  a_linear: assert property (p_linear) else $error("linear map outside GPR");
endmodule

/* bench/tb_cspc_core.sv */
// Self-checking bench for the CPU stack and pointer core
`timescale 1ns/1ps
module tb_cspc_core;
  import cspc_pkg::*;
  typedef struct {
    logic [6:0] insn;
    logic legal;
    logic [15:0] ptr;
    logic [7:0] rd;
    logic [11:0] addr;
  } cspc_row_t;
  logic clk, arst_n, stack_rst_en, flag_clr_ovf, flag_clr_unf, irq_enter, irq_return;
  logic ptr_wr, ptr_wr_sel, stack_overflow_flag, stack_underflow_flag, soft_reset;
  logic restore_valid, data_we, ind_done, cpu_stall, insn_legal;
  cspc_stack_op_t stack_op;
  logic [14:0] ret_addr, ret_top, prog_addr;
  cspc_context_t live_ctx, shadow_ctx, ctx_exp;
  logic [15:0] ptr_wr_data, indirect_address_pointer0, indirect_address_pointer1;
  cspc_ind_req_t ind_req;
  logic [13:0] prog_rdata;
  logic [7:0] data_rdata, data_wdata, indirect_data_port;
  logic [6:0] insn_index;
  logic [11:0] data_addr;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int k;
  cspc_row_t rows[5] = '{'{7'd0, 1'b1, 16'h0123, 8'h5a, 12'h123},
    '{7'd48, 1'b1, 16'h2000, 8'ha5, 12'h020}, '{7'd49, 1'b0, 16'h204f, 8'h3c, 12'h06f},
    '{7'd127, 1'b0, 16'h2050, 8'hc3, 12'h0a0}, '{7'd22, 1'b1, 16'h29af, 8'h81, 12'hf6f}};

  cspc_core DUT (.clk(clk), .arst_n(arst_n), .stack_op(stack_op), .ret_addr(ret_addr),
    .stack_rst_en(stack_rst_en), .flag_clr_ovf(flag_clr_ovf), .flag_clr_unf(flag_clr_unf),
    .irq_enter(irq_enter), .irq_return(irq_return), .live_ctx(live_ctx), .ptr_wr(ptr_wr),
    .ptr_wr_sel(ptr_wr_sel), .ptr_wr_data(ptr_wr_data), .ind_req(ind_req),
    .prog_rdata(prog_rdata), .data_rdata(data_rdata), .insn_index(insn_index),
    .ret_top(ret_top), .stack_overflow_flag(stack_overflow_flag),
    .stack_underflow_flag(stack_underflow_flag), .soft_reset(soft_reset),
    .shadow_ctx(shadow_ctx), .restore_valid(restore_valid),
    .indirect_address_pointer0(indirect_address_pointer0),
    .indirect_address_pointer1(indirect_address_pointer1), .prog_addr(prog_addr),
    .data_addr(data_addr), .data_we(data_we), .data_wdata(data_wdata),
    .indirect_data_port(indirect_data_port), .ind_done(ind_done), .cpu_stall(cpu_stall),
    .insn_legal(insn_legal));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_evt(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Soft reset pulses seen over three cycles
  task automatic pulses(output int c);
    c = int'(soft_reset === 1'b1);
    repeat (2) begin
      step(1);
      c += int'(soft_reset === 1'b1);
    end
  endtask

  task automatic set_ptr(input logic sel, input logic [15:0] v);
    ptr_wr = 1'b1;
    ptr_wr_sel = sel;
    ptr_wr_data = v;
    step(1);
    ptr_wr = 1'b0;
  endtask

  task automatic stack_run(input int n, input cspc_stack_op_t op);
    stack_op = op;
    for (int i = 0; i < n; i++) begin
      ret_addr = 15'h100 + 15'(i);
      step(1);
      if (op == CSPC_OP_POP && i < STACK_DEPTH) chk_val(ret_top, 15'h10f - 15'(i));
    end
    stack_op = CSPC_OP_NONE;
  endtask

  initial begin
    {arst_n, stack_rst_en, flag_clr_ovf, flag_clr_unf, irq_enter, irq_return} = '0;
    {ptr_wr, ptr_wr_sel, ptr_wr_data, prog_rdata, data_rdata, insn_index} = '0;
    stack_op = CSPC_OP_NONE;
    ret_addr = '0;
    live_ctx = '0;
    ind_req = '0;
    step(4);
    arst_n = 1'b1;
    chk_val({ret_top, stack_overflow_flag, stack_underflow_flag}, '0);
    foreach (rows[i]) begin
      insn_index = rows[i].insn;
      set_ptr(1'b0, rows[i].ptr);
      chk_val(indirect_address_pointer0, rows[i].ptr);
      chk_val(insn_legal, rows[i].legal);
      ind_req = {1'b1, 1'b0, 1'b0, 8'h00};
      data_rdata = rows[i].rd;
      step(1);
      ind_req = '0;
      chk_val({data_addr, indirect_data_port, ind_done}, {rows[i].addr, rows[i].rd, 1'b1});
    end
    $display("test rows done");
    ind_req = {1'b1, 1'b0, 1'b1, 8'h77};
    step(1);
    ind_req = '0;
    chk_val({data_we, data_wdata, data_addr}, {1'b1, 8'h77, 12'hf6f});
    set_ptr(1'b1, 16'h8005);
    chk_val(indirect_address_pointer1, 16'h8005);
    prog_rdata = 14'h3abc;
    ind_req = {1'b1, 1'b1, 1'b0, 8'h00};
    step(1);
    ind_req = '0;
    chk_val({cpu_stall, ind_done, prog_addr}, {2'b10, 15'h0005});
    step(1);
    chk_val({ind_done, indirect_data_port}, {1'b1, 8'hbc});
    ind_req = {1'b1, 1'b1, 1'b1, 8'h55};
    step(1);
    ind_req = '0;
    k = int'(data_we === 1'b1);
    repeat (2) begin
      step(1);
      k += int'(data_we === 1'b1);
    end
    chk_evt(k, 0);
    $display("test indirect done");
    ctx_exp = {8'h3c, 3'h5, 5'h11, 7'h2a, 16'h1234, 16'habcd};
    live_ctx = ctx_exp;
    irq_enter = 1'b1;
    step(1);
    {irq_enter, live_ctx} = '0;
    irq_return = 1'b1;
    step(1);
    irq_return = 1'b0;
    chk_val({restore_valid, shadow_ctx}, {1'b1, ctx_exp});
    $display("test context done");
    stack_run(STACK_DEPTH, CSPC_OP_PUSH);
    stack_run(STACK_DEPTH + 1, CSPC_OP_POP);
    pulses(k);
    chk_evt(k, 0);
    chk_val({stack_overflow_flag, stack_underflow_flag}, 2'b01);
    flag_clr_unf = 1'b1;
    step(1);
    flag_clr_unf = 1'b0;
    chk_val(stack_underflow_flag, 1'b0);
    stack_rst_en = 1'b1;
    stack_run(STACK_DEPTH + 1, CSPC_OP_PUSH);
    pulses(k);
    chk_evt(k, 1);
    chk_val(stack_overflow_flag, 1'b1);
    // Stack must be empty after the forced reset
    stack_run(1, CSPC_OP_NONE);
    stack_op = CSPC_OP_POP;
    step(1);
    stack_op = CSPC_OP_NONE;
    pulses(k);
    chk_evt(k, 1);
    chk_val({stack_overflow_flag, stack_underflow_flag}, 2'b11);
    // Clear meets a fresh underflow: set wins, idle flag clears
    flag_clr_ovf = 1'b1;
    flag_clr_unf = 1'b1;
    stack_op = CSPC_OP_POP;
    step(1);
    {flag_clr_ovf, flag_clr_unf} = '0;
    stack_op = CSPC_OP_NONE;
    chk_val({stack_overflow_flag, stack_underflow_flag}, 2'b01);
    arst_n = 1'b0;
    step(1);
    chk_val({ret_top, stack_overflow_flag, stack_underflow_flag}, '0);
    arst_n = 1'b1;
    $display("test stack done");
    test_done();
  end
endmodule
